// ==== rtl/aai_defines.svh ====
// register map, field positions, reset values and timing counts of the interrupt logic
`ifndef AAI_DEFINES_SVH
`define AAI_DEFINES_SVH
`define AAI_ADDR_W 8
`define AAI_OFS_INT_CFG 8'h32
`define AAI_OFS_EVENT_MASK 8'h33
`define AAI_OFS_EVENT_LATCH 8'h36
`define AAI_PAGE_MAIN 8'h00
`define AAI_CFG_POL_BIT 7
`define AAI_CFG_STYLE_HI 6
`define AAI_CFG_STYLE_LO 5
`define AAI_CFG_VIEW_BIT 2
`define AAI_CFG_WMASK 8'he4
`define AAI_CFG_RESET 8'h00
`define AAI_MASK_RESET 8'hff
`define AAI_LATCH_RESET 8'h00
`define AAI_LATCH_WMASK 8'hc0
`define AAI_BIT_CLK_ERR 7
`define AAI_BIT_PLL_LOCK 6
`define AAI_CLK_HZ 40000000
`define AAI_PULSE_MS 2
`define AAI_PERIOD_MS 4
`define AAI_PULSE_CYC ((`AAI_CLK_HZ / 1000) * `AAI_PULSE_MS)
`define AAI_PERIOD_CYC ((`AAI_CLK_HZ / 1000) * `AAI_PERIOD_MS)
`endif

// ==== rtl/aai_pkg.sv ====
// types shared by the interrupt logic files
package aai_pkg;
   typedef enum logic [1:0] {
      AAI_STYLE_LEVEL = 2'b00,
      AAI_STYLE_RSVD = 2'b01,
      AAI_STYLE_REPEAT = 2'b10,
      AAI_STYLE_SINGLE = 2'b11
   } aai_style_t;
   typedef struct packed {
      logic irq_polarity_sel;
      aai_style_t style;
      logic latch_view_sel;
   } aai_cfg_t;
endpackage

// ==== rtl/aai_pulse_gen.sv ====
// pulse timer that shapes the interrupt output in the repeating and single-pulse styles
`timescale 1ns/1ps
`default_nettype none
`include "aai_defines.svh"
module aai_pulse_gen #(
   parameter int unsigned PULSE_CYC = `AAI_PULSE_CYC,
   parameter int unsigned PERIOD_CYC = `AAI_PERIOD_CYC
) (
   input wire logic clk,
   input wire logic arst_n,
   input wire aai_pkg::aai_style_t style,
   input wire logic pending,
   input wire logic new_event,
   output logic active
);
   localparam int CW = $clog2(PERIOD_CYC + 1);
   typedef enum logic [1:0] {
      PG_IDLE = 2'b00,
      PG_HIGH = 2'b01,
      PG_LOW = 2'b10
   } aai_pg_state_t;
   aai_pg_state_t state_q;
   logic [CW-1:0] cnt_q;
   logic pulse_end;
   logic period_end;
   assign pulse_end = (cnt_q == CW'(PULSE_CYC - 1));
   assign period_end = (cnt_q == CW'(PERIOD_CYC - 1));

   // a fresh event in single style restarts a running pulse, so each event gets a full width
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         state_q <= PG_IDLE;
         cnt_q <= '0;
      end else begin
         unique case (state_q)
            PG_IDLE: begin
               cnt_q <= '0;
               if ((style == aai_pkg::AAI_STYLE_REPEAT && pending) ||
                   (style == aai_pkg::AAI_STYLE_SINGLE && new_event)) begin
                  state_q <= PG_HIGH;
               end
            end
            PG_HIGH: begin
               cnt_q <= cnt_q + 1'b1;
               if (style == aai_pkg::AAI_STYLE_SINGLE && new_event) begin
                  cnt_q <= '0;
               end else if (pulse_end) begin
                  state_q <= (style == aai_pkg::AAI_STYLE_REPEAT) ? PG_LOW : PG_IDLE;
                  if (style != aai_pkg::AAI_STYLE_REPEAT) cnt_q <= '0;
               end
            end
            PG_LOW: begin
               cnt_q <= cnt_q + 1'b1;
               if (style != aai_pkg::AAI_STYLE_REPEAT) begin
                  // a single-style event caught in the gap must still get its own pulse
                  cnt_q <= '0;
                  state_q <= (style == aai_pkg::AAI_STYLE_SINGLE && new_event) ? PG_HIGH : PG_IDLE;
               end else if (period_end) begin
                  cnt_q <= '0;
                  state_q <= pending ? PG_HIGH : PG_IDLE;
               end
            end
            default: state_q <= PG_IDLE;
         endcase
      end
   end

   // the active level is only meaningful while the style selects a timed pulse
   assign active = (state_q == PG_HIGH);

   a_pulse_width: assert property (@(posedge clk) disable iff (!arst_n)
      $rose(active) && style == aai_pkg::AAI_STYLE_REPEAT |-> active [*8])
      else $error("repeat pulse ended too early");
endmodule
`default_nettype wire

// ==== rtl/aai_irq_ctrl.sv ====
// interrupt controller: config, mask and latch registers driving one interrupt pin
`timescale 1ns/1ps
`default_nettype none
`include "aai_defines.svh"
module aai_irq_ctrl #(
   parameter int unsigned PULSE_CYC = `AAI_PULSE_CYC,
   parameter int unsigned PERIOD_CYC = `AAI_PERIOD_CYC
) (
   input wire logic CLK_SYS,
   input wire logic ARST_N,
   input wire logic [7:0] REG_PAGE,
   input wire logic [7:0] REG_ADDR,
   input wire logic REG_WR,
   input wire logic REG_RD,
   input wire logic [7:0] REG_WDATA,
   output logic [7:0] REG_RDATA,
   input wire logic AUDIO_SERIAL_PORT_CLK_ERR,
   input wire logic PLL_LOCK_EVENT,
   output logic INTERRUPT_OUT,
   output logic INTERRUPT_OUT_ACTIVE
);
   ////////////////////////////////////////////////////////////////////////////
   // register storage
   aai_pkg::aai_cfg_t cfg_q;
   logic [7:0] event_mask_reg_q;
   logic [1:0] latch_q;
   logic [7:0] rdata_q;
   logic irq_q;
   logic [1:0] ev_in;
   logic [1:0] ev_prev_q;
   logic [1:0] ev_rise;
   logic [1:0] mask_bits;
   logic [1:0] unmasked;
   logic page_ok;
   logic sel_cfg;
   logic sel_mask;
   logic sel_latch;
   logic pending;
   logic new_event;
   logic pulse_active;
   logic assert_int;
   logic [7:0] cfg_byte;
   logic [7:0] latch_view;

   // decode one register address on the main page
   function automatic logic hit(input logic [7:0] addr, input logic [7:0] ofs);
      hit = (addr == ofs);
   endfunction

   assign page_ok = (REG_PAGE == `AAI_PAGE_MAIN);
   assign sel_cfg = page_ok && hit(REG_ADDR, `AAI_OFS_INT_CFG);
   assign sel_mask = page_ok && hit(REG_ADDR, `AAI_OFS_EVENT_MASK);
   assign sel_latch = page_ok && hit(REG_ADDR, `AAI_OFS_EVENT_LATCH);

   // configuration register, reserved bits hold zero
   always_ff @(posedge CLK_SYS or negedge ARST_N) begin
      if (!ARST_N) begin
         cfg_q <= '0;
      end else if (REG_WR && sel_cfg) begin
         cfg_q.irq_polarity_sel <= REG_WDATA[`AAI_CFG_POL_BIT];
         cfg_q.style <= aai_pkg::aai_style_t'(REG_WDATA[`AAI_CFG_STYLE_HI:`AAI_CFG_STYLE_LO]);
         cfg_q.latch_view_sel <= REG_WDATA[`AAI_CFG_VIEW_BIT];
      end
   end

   // mask register, all eight bits read-write, everything masked out of reset
   always_ff @(posedge CLK_SYS or negedge ARST_N) begin
      if (!ARST_N) begin
         event_mask_reg_q <= `AAI_MASK_RESET;
      end else if (REG_WR && sel_mask) begin
         event_mask_reg_q <= REG_WDATA;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // event capture
   assign ev_in = {AUDIO_SERIAL_PORT_CLK_ERR, PLL_LOCK_EVENT};
   assign ev_rise = ev_in & ~ev_prev_q;
   assign mask_bits = {event_mask_reg_q[`AAI_BIT_CLK_ERR], event_mask_reg_q[`AAI_BIT_PLL_LOCK]};

   // edge detect so a held event level counts as one occurrence
   always_ff @(posedge CLK_SYS or negedge ARST_N) begin
      if (!ARST_N) begin
         ev_prev_q <= '0;
      end else begin
         ev_prev_q <= ev_in;
      end
   end

   // latch regardless of mask; new event beats the read clear
   always_ff @(posedge CLK_SYS or negedge ARST_N) begin
      if (!ARST_N) begin
         latch_q <= '0;
      end else begin
         latch_q <= ((REG_RD && sel_latch) ? 2'b00 : latch_q) | ev_rise;
      end
   end

   assign unmasked = latch_q & ~mask_bits;
   assign pending = |unmasked;
   assign new_event = |(ev_rise & ~mask_bits);

   ////////////////////////////////////////////////////////////////////////////
   // read path
   assign cfg_byte = {cfg_q.irq_polarity_sel, cfg_q.style, 2'b00, cfg_q.latch_view_sel, 2'b00};
   assign latch_view = {cfg_q.latch_view_sel ? unmasked : latch_q, 6'h00};

   // registered read data; unmapped addresses answer zero
   always_ff @(posedge CLK_SYS or negedge ARST_N) begin
      if (!ARST_N) begin
         rdata_q <= 8'h00;
      end else if (REG_RD) begin
         rdata_q <= sel_cfg ? cfg_byte : sel_mask ? event_mask_reg_q : sel_latch ? latch_view : 8'h00;
      end
   end
   assign REG_RDATA = rdata_q;

   ////////////////////////////////////////////////////////////////////////////
   // interrupt output shaping
   aai_pulse_gen #(
      .PULSE_CYC(PULSE_CYC),
      .PERIOD_CYC(PERIOD_CYC)
   ) u_pulse (
      .clk(CLK_SYS),
      .arst_n(ARST_N),
      .style(cfg_q.style),
      .pending(pending),
      .new_event(new_event),
      .active(pulse_active)
   );

   // reserved style 1 is treated as never asserting, the safe choice for a host
   always_comb begin
      unique case (cfg_q.style)
         aai_pkg::AAI_STYLE_LEVEL: assert_int = pending;
         aai_pkg::AAI_STYLE_RSVD: assert_int = 1'b0;
         aai_pkg::AAI_STYLE_REPEAT: assert_int = pulse_active;
         aai_pkg::AAI_STYLE_SINGLE: assert_int = pulse_active;
      endcase
   end

   // pin level registered so polarity changes never glitch the pin
   always_ff @(posedge CLK_SYS or negedge ARST_N) begin
      if (!ARST_N) begin
         irq_q <= 1'b1;
      end else begin
         irq_q <= cfg_q.irq_polarity_sel ? assert_int : ~assert_int;
      end
   end
   assign INTERRUPT_OUT = irq_q;
   assign INTERRUPT_OUT_ACTIVE = (irq_q == cfg_q.irq_polarity_sel);

   ////////////////////////////////////////////////////////////////////////////
   // checks
   a_pol_level: assert property (@(posedge CLK_SYS) disable iff (!ARST_N)
      irq_q == ($past(cfg_q.irq_polarity_sel) ? $past(assert_int) : ~$past(assert_int)))
      else $error("interrupt pin polarity wrong");
   a_level_style: assert property (@(posedge CLK_SYS) disable iff (!ARST_N)
      cfg_q.style == aai_pkg::AAI_STYLE_LEVEL && pending |=> irq_q == $past(cfg_q.irq_polarity_sel))
      else $error("level style not asserted");
   a_single_pulse: assert property (@(posedge CLK_SYS) disable iff (!ARST_N)
      cfg_q.style == aai_pkg::AAI_STYLE_SINGLE && new_event |=> pulse_active)
      else $error("single pulse missing");
   a_view_all: assert property (@(posedge CLK_SYS) disable iff (!ARST_N)
      REG_RD && sel_latch && !cfg_q.latch_view_sel |=> REG_RDATA[7:6] == $past(latch_q))
      else $error("latch view all wrong");
   a_view_unmasked: assert property (@(posedge CLK_SYS) disable iff (!ARST_N)
      REG_RD && sel_latch && cfg_q.latch_view_sel |=> REG_RDATA[7:6] == $past(unmasked))
      else $error("latch view unmasked wrong");
   a_latch_set: assert property (@(posedge CLK_SYS) disable iff (!ARST_N)
      ev_rise[1] |=> latch_q[1])
      else $error("clock error not latched");
   a_pll_set: assert property (@(posedge CLK_SYS) disable iff (!ARST_N)
      ev_rise[0] |=> latch_q[0])
      else $error("pll lock not latched");
   a_read_clear: assert property (@(posedge CLK_SYS) disable iff (!ARST_N)
      REG_RD && sel_latch && ev_rise == 2'b00 |=> latch_q == 2'b00)
      else $error("latch not cleared by read");
   a_low_zero: assert property (@(posedge CLK_SYS) disable iff (!ARST_N)
      $past(REG_RD) && $past(sel_latch) |-> REG_RDATA[5:0] == 6'h00)
      else $error("latch reserved bits nonzero");
   a_mask_write: assert property (@(posedge CLK_SYS) disable iff (!ARST_N)
      REG_WR && sel_mask |=> event_mask_reg_q == $past(REG_WDATA))
      else $error("mask write lost");
   c_level_irq: cover property (@(posedge CLK_SYS) disable iff (!ARST_N)
      cfg_q.style == aai_pkg::AAI_STYLE_LEVEL && INTERRUPT_OUT_ACTIVE);
   c_repeat_irq: cover property (@(posedge CLK_SYS) disable iff (!ARST_N)
      cfg_q.style == aai_pkg::AAI_STYLE_REPEAT && $rose(pulse_active));
   c_single_irq: cover property (@(posedge CLK_SYS) disable iff (!ARST_N)
      cfg_q.style == aai_pkg::AAI_STYLE_SINGLE && $fell(pulse_active));
   c_set_on_read: cover property (@(posedge CLK_SYS) disable iff (!ARST_N)
      REG_RD && sel_latch && |ev_rise);
endmodule
`default_nettype wire

// ==== test/aai_host_model.sv ====
// host-side watcher of the interrupt pin: counts assertions and asserted cycles
`timescale 1ns/1ps
`default_nettype none
module aai_host_model (
   input wire logic clk,
   input wire logic pin,
   input wire logic pol,
   input wire logic clr,
   output logic [15:0] n_rise,
   output logic [15:0] n_high
);
   logic asserted;
   logic seen_q;
   // the pin shows asserted when it matches the chosen polarity
   assign asserted = (pin === pol);
   ////////////////////////////////////////////////////////////////////////////
   // counters restart on clr so each window is judged on its own
   always_ff @(posedge clk) begin
      seen_q <= asserted;
      if (clr) begin
         n_rise <= 16'h0000;
         n_high <= 16'h0000;
      end else begin
         n_rise <= n_rise + 16'((asserted && !seen_q) ? 1 : 0);
         n_high <= n_high + 16'(asserted ? 1 : 0);
      end
   end
endmodule
`default_nettype wire

// ==== test/tb_top.sv ====
// self-checking testbench of the interrupt controller
`timescale 1ns/1ps
`default_nettype none
`include "aai_defines.svh"
module tb_top;
   localparam int PW = 10;
   localparam int PD = 20;
   logic clk = 0, arst_n = 0, rd = 0, wr = 0, ev_ck = 0, ev_pll = 0, clr = 0, pol = 0;
   logic [7:0] page = 8'h00, addr = 8'h00, wdata = 8'h00, rdata, r;
   logic irq, irq_act;
   logic [15:0] n_rise, n_high;
   logic [7:0] st_cfg [3] = '{8'ha0, 8'hc0, 8'he0};
   logic [15:0] st_rise [3] = '{16'h0000, 16'h0003, 16'h0001};
   int n_mismatch = 0, comparisons = 0;
   // short pulse counts keep the timed styles quick to simulate
   initial forever #12.5 clk = ~clk;
   aai_irq_ctrl #(.PULSE_CYC(PW), .PERIOD_CYC(PD)) DUT (.CLK_SYS(clk), .ARST_N(arst_n),
      .REG_PAGE(page), .REG_ADDR(addr), .REG_WR(wr), .REG_RD(rd), .REG_WDATA(wdata),
      .REG_RDATA(rdata), .AUDIO_SERIAL_PORT_CLK_ERR(ev_ck), .PLL_LOCK_EVENT(ev_pll),
      .INTERRUPT_OUT(irq), .INTERRUPT_OUT_ACTIVE(irq_act));
   aai_host_model host (.clk(clk), .pin(irq), .pol(pol), .clr(clr), .n_rise(n_rise), .n_high(n_high));
   ////////////////////////////////////////////////////////////////////////////
   task automatic wrap_up;
      $display("mismatches %0d comparisons %0d", n_mismatch, comparisons);
      if (n_mismatch == 0 && comparisons > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
   endtask
   task automatic chk(input string name, input logic [15:0] seen, input logic [15:0] exp);
      comparisons++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("mismatch %s expected %h seen %h", name, exp, seen);
      end
   endtask
   // one-cycle strobes; the next call waits a fresh edge, so no double drive
   task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
      @(posedge clk);
      addr <= a;
      wdata <= d;
      wr <= 1;
      @(posedge clk);
      wr <= 0;
   endtask
   task automatic rd_reg(input logic [7:0] a);
      @(posedge clk);
      addr <= a;
      rd <= 1;
      @(posedge clk);
      rd <= 0;
      #1 r = rdata;
   endtask
   task automatic cfg(input logic [7:0] d);
      wr_reg(`AAI_OFS_INT_CFG, d);
      pol = d[7];
   endtask
   task automatic fire(input bit ck);
      @(posedge clk);
      if (ck) ev_ck <= 1;
      else ev_pll <= 1;
      @(posedge clk);
      ev_ck <= 0;
      ev_pll <= 0;
   endtask
   task automatic cyc(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask
   ////////////////////////////////////////////////////////////////////////////
   // a hang counts as a failure
   initial begin
      #(25 * 4000);
      n_mismatch++;
      wrap_up();
   end
   // main sequence
   initial begin
      repeat (3) @(posedge clk);
      arst_n <= 1;
      #1 chk("pin_reset", irq, 1'h1);
      chk("act_reset", irq_act, 1'h0);
      rd_reg(`AAI_OFS_INT_CFG); chk("cfg_reset", r, 8'h00);
      rd_reg(`AAI_OFS_EVENT_MASK); chk("mask_reset", r, 8'hff);
      rd_reg(`AAI_OFS_EVENT_LATCH); chk("latch_reset", r, 8'h00);
      cfg(8'hff); rd_reg(`AAI_OFS_INT_CFG); chk("cfg_rsvd", r, 8'he4);
      wr_reg(`AAI_OFS_EVENT_LATCH, 8'hff); rd_reg(`AAI_OFS_EVENT_LATCH); chk("latch_ro", r, 8'h00);
      rd_reg(8'h40); chk("unmapped", r, 8'h00);
      @(posedge clk) page <= 8'h01;
      wr_reg(`AAI_OFS_EVENT_MASK, 8'h00);
      @(posedge clk) page <= 8'h00;
      rd_reg(`AAI_OFS_EVENT_MASK); chk("mask_page", r, 8'hff);
      wr_reg(`AAI_OFS_EVENT_MASK, 8'h3f); rd_reg(`AAI_OFS_EVENT_MASK); chk("mask_rw", r, 8'h3f);
      // level style, active low then active high: held until the latch is read
      cfg(8'h00); fire(0); cyc(2); chk("level_pin", irq, 1'h0);
      chk("level_act", irq_act, 1'h1);
      rd_reg(`AAI_OFS_EVENT_LATCH); chk("latch_pll", r, 8'h40);
      cyc(2); chk("level_clear", irq, 1'h1);
      rd_reg(`AAI_OFS_EVENT_LATCH); chk("latch_cleared", r, 8'h00);
      cfg(8'h80); fire(1); cyc(2); chk("high_pin", irq, 1'h1);
      chk("high_act", irq_act, 1'h1);
      rd_reg(`AAI_OFS_EVENT_LATCH); chk("latch_clk", r, 8'h80);
      // masked sources latch but leave the pin alone
      wr_reg(`AAI_OFS_EVENT_MASK, 8'hbf); cfg(8'h00); fire(1); cyc(4); chk("masked_pin", irq, 1'h1);
      rd_reg(`AAI_OFS_EVENT_LATCH); chk("view_all", r, 8'h80);
      cfg(8'h04); fire(1); fire(0); cyc(2);
      rd_reg(`AAI_OFS_EVENT_LATCH); chk("view_unmasked", r, 8'h40);
      wr_reg(`AAI_OFS_EVENT_MASK, 8'h40); fire(0); cyc(4); chk("pll_masked", irq, 1'h1);
      rd_reg(`AAI_OFS_EVENT_LATCH); chk("view_masked", r, 8'h00);
      // reserved, repeating and single styles, all active high
      wr_reg(`AAI_OFS_EVENT_MASK, 8'h3f);
      for (int i = 0; i < 3; i++) begin
         cfg(st_cfg[i]);
         @(posedge clk) clr <= 1;
         @(posedge clk) clr <= 0;
         fire(0);
         cyc(60);
         chk("style_rises", n_rise, st_rise[i]);
         if (i == 1) chk("repeat_high", n_high, 16'(3 * PW));
         if (i == 2) chk("single_high", 16'(n_high >= PW && n_high <= PW + 1), 16'h0001);
         rd_reg(`AAI_OFS_EVENT_LATCH);
         cyc(PD + 5);
         chk("style_idle", irq, 1'h0);
         chk("style_idle_act", irq_act, 1'h0);
      end
      wrap_up();
   end
endmodule
`default_nettype wire
